// *** sas_pkg.sv ***
// package for the successive-approximation converter sequencer
package sas_pkg;
    // register byte addresses (one word each, all aligned except control at f7)
    localparam logic [7:0] OFF_CONTROL   = 8'hf7;
    localparam logic [7:0] OFF_RES_HIGH  = 8'hf8;
    localparam logic [7:0] OFF_RES_LOW   = 8'hfc;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'he0;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'he4;
    localparam logic [7:0] OFF_DIG_IN    = 8'he8;
    // control register fields
    localparam int CTL_START_BIT = 0;
    localparam int CTL_SPEED_LSB = 1;
    localparam int CTL_EOC_BIT   = 3;
    localparam int CTL_CHAN_LSB  = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] MASK_RESET    = 2'h0;
    // conversion geometry and timing, in conversion clocks
    localparam int RESULT_BITS  = 10;
    localparam int CHANNELS     = 9;
    localparam int CLK_PER_BIT  = 4;
    localparam int SETUP_CLOCKS = 10;
    localparam logic [9:0] SAR_MIDPOINT = 10'h200;
    // oscillator division per speed code
    localparam logic [4:0] DIV_CODE00 = 5'h10;
    localparam logic [4:0] DIV_CODE01 = 5'h08;
    localparam logic [4:0] DIV_CODE10 = 5'h04;
    localparam logic [4:0] DIV_CODE11 = 5'h01;
    // interrupt status bits
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_START_BIT = 1;
    // control fields carried together
    typedef struct packed {
        logic [3:0] chan;
        logic       eoc;
        logic [1:0] speed;
        logic       start;
    } sas_ctl_t;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SETUP = 3'b010,
        ST_TRIAL = 3'b100
    } sas_state_t;
endpackage

// *** sas_clkdiv.sv ***
// conversion clock enable divider selected by the speed code
module sas_clkdiv (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // control
    input  wire logic       run_i,
    input  wire logic [1:0] speed_i,
    // one-cycle conversion clock enable
    output logic            tick_o
);
    logic [4:0] count;
    logic [4:0] div;

    // speed code to division ratio
    assign div = (speed_i == 2'b00) ? sas_pkg::DIV_CODE00 :
                 (speed_i == 2'b01) ? sas_pkg::DIV_CODE01 :
                 (speed_i == 2'b10) ? sas_pkg::DIV_CODE10 : sas_pkg::DIV_CODE11;
    assign tick_o = run_i && (count == div - 5'h01);

    // divider counter, held at zero while idle
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i || tick_o)
            count <= 5'h00;
        else
            count <= count + 5'h01;
    end
endmodule

// *** sas_sequencer.sv ***
// successive-approximation converter sequencer with wishbone registers
// Summary of operation
// - ten-bit result by successive approximation, one comparator decision per bit
// - approximation register loads midpoint code at every conversion start
// - approximation register updates after each comparison until ten bits done
// - upper control nibble selects one of nine inputs, one at a time
// - writing one to control bit zero starts a conversion
// - control bits two and one select the conversion clock rate
// - four conversion clocks per bit plus ten set-up clocks
// - end-of-conversion bit three set after the full clock count
// - upper eight bits to high register, lower two to low, then idle
// - new conversion overwrites results without protection
// - analog pins remain readable as digital inputs
//
// Added by the designer: register access over Wishbone.
module sas_sequencer #(
    parameter int NUM_CHAN = sas_pkg::CHANNELS
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic [31:0]              dat_o,
    output logic                     ack_o,
    // analog front end
    input  wire logic                cmp_i,
    output logic [9:0]               dac_o,
    output logic [NUM_CHAN-1:0]      mux_sel_o,
    output logic                     sample_o,
    // analog pins as digital inputs
    input  wire logic [NUM_CHAN-1:0] pin_i,
    // interrupt
    output logic                     irq_o
);
    // refuse channel counts that the four-bit channel field cannot address
    if (NUM_CHAN < 1 || NUM_CHAN > 16)
    begin : g_bad_chan
        $error("channel count must be 1 to 16");
    end

    sas_pkg::sas_ctl_t   ctl;
    sas_pkg::sas_state_t state;
    logic [9:0]  sar;
    logic [9:0]  bitmask;
    logic [3:0]  step;
    logic [1:0]  phase;
    logic        cmp_s1;
    logic        cmp_s2;
    logic [NUM_CHAN-1:0] pin_s1;
    logic [NUM_CHAN-1:0] pin_s2;
    logic [7:0]  res_high;
    logic [1:0]  res_low;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [31:0] next_dat;

    // bus decode
    // a request is taken only while ack is low, so one strobe never acts twice
    wire req       = cyc_i && stb_i && !ack_o;
    wire wr_lane0  = req && we_i && sel_i[0];
    wire rd        = req && !we_i;
    wire hit_ctl   = adr_i == sas_pkg::OFF_CONTROL;
    wire hit_hi    = adr_i == sas_pkg::OFF_RES_HIGH;
    wire hit_lo    = adr_i == sas_pkg::OFF_RES_LOW;
    wire hit_stat  = adr_i == sas_pkg::OFF_IRQ_STAT;
    wire hit_mask  = adr_i == sas_pkg::OFF_IRQ_MASK;
    wire hit_dig   = adr_i == sas_pkg::OFF_DIG_IN;
    wire start_req = wr_lane0 && hit_ctl && dat_i[sas_pkg::CTL_START_BIT];
    wire busy      = state != sas_pkg::ST_IDLE;
    wire go        = start_req && !busy;
    wire stat_rd   = rd && hit_stat;

    // conversion clock enable
    wire tick;
    sas_clkdiv u_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .run_i   (busy),
        .speed_i (ctl.speed),
        .tick_o  (tick)
    );

    // sequencing events
    wire setup_end = (state == sas_pkg::ST_SETUP) && tick && step == 4'(sas_pkg::SETUP_CLOCKS - 1);
    wire decide    = (state == sas_pkg::ST_TRIAL) && tick && phase == 2'(sas_pkg::CLK_PER_BIT - 1);
    wire last_bit  = decide && bitmask[0];
    wire [9:0] kept = cmp_s2 ? sar : (sar & ~bitmask);

    // front end drive
    assign dac_o    = sar;
    assign sample_o = busy;
    assign irq_o    = |(irq_stat & irq_mask);

    // one-hot channel select, unused codes select nothing
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++)
        begin : g_mux
            assign mux_sel_o[g] = busy && (ctl.chan == 4'(g));
        end
    endgenerate

    // input synchronisers
    // comparator and pins are asynchronous, two flops guard against metastability
    always_ff @(posedge clk_i)
    begin
        cmp_s1 <= cmp_i;
        cmp_s2 <= cmp_s1;
        pin_s1 <= pin_i;
        pin_s2 <= pin_s1;
    end

    // control register: channel and speed only change while idle
    // a write during a conversion is dropped whole, so the running channel cannot move
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctl <= sas_pkg::CONTROL_RESET;
        else if (wr_lane0 && hit_ctl && !busy)
        begin
            ctl.chan  <= dat_i[sas_pkg::CTL_CHAN_LSB +: 4];
            ctl.speed <= dat_i[sas_pkg::CTL_SPEED_LSB +: 2];
            ctl.start <= dat_i[sas_pkg::CTL_START_BIT];
            if (go)
                ctl.eoc <= 1'b0;
        end
        else if (last_bit)
        begin
            ctl.start <= 1'b0;
            ctl.eoc   <= 1'b1;
        end
    end

    // state machine and approximation register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state   <= sas_pkg::ST_IDLE;
            sar     <= 10'h000;
            bitmask <= 10'h000;
            step    <= 4'h0;
            phase   <= 2'h0;
        end
        else
        begin
            case (state)
                sas_pkg::ST_IDLE:
                begin
                    if (go)
                    begin
                        state   <= sas_pkg::ST_SETUP;
                        sar     <= sas_pkg::SAR_MIDPOINT;
                        bitmask <= sas_pkg::SAR_MIDPOINT;
                        step    <= 4'h0;
                        phase   <= 2'h0;
                    end
                end
                sas_pkg::ST_SETUP:
                begin
                    if (setup_end)
                        state <= sas_pkg::ST_TRIAL;
                    else if (tick)
                        step <= step + 4'h1;
                end
                sas_pkg::ST_TRIAL:
                begin
                    if (tick)
                        phase <= phase + 2'h1;
                    if (decide)
                    begin
                        sar     <= kept | (bitmask >> 1);
                        bitmask <= bitmask >> 1;
                        if (last_bit)
                            state <= sas_pkg::ST_IDLE;
                    end
                end
                default:
                    state <= sas_pkg::ST_IDLE;
            endcase
        end
    end

    // result registers, overwritten by each completion
    // nothing guards an unread result, software reads it before the next start
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            res_high <= 8'h00;
            res_low  <= 2'h0;
        end
        else if (last_bit)
        begin
            res_high <= kept[9:2];
            res_low  <= kept[1:0];
        end
    end

    // interrupt status: set wins over read clear
    // a completion that lands on the clearing read is kept, so no event is lost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_stat <= 2'h0;
        else
        begin
            irq_stat[sas_pkg::IRQ_DONE_BIT]  <= last_bit ||
                (irq_stat[sas_pkg::IRQ_DONE_BIT] && !stat_rd);
            irq_stat[sas_pkg::IRQ_START_BIT] <= go ||
                (irq_stat[sas_pkg::IRQ_START_BIT] && !stat_rd);
        end
    end

    // interrupt mask
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask <= sas_pkg::MASK_RESET;
        else if (wr_lane0 && hit_mask)
            irq_mask <= dat_i[1:0];
    end

    // read mux, unmapped addresses read zero
    always_comb
    begin
        next_dat = 32'h0000_0000;
        if (hit_ctl)
            next_dat[7:0] = ctl;
        else if (hit_hi)
            next_dat[7:0] = res_high;
        else if (hit_lo)
            next_dat[1:0] = res_low;
        else if (hit_stat)
            next_dat[1:0] = irq_stat;
        else if (hit_mask)
            next_dat[1:0] = irq_mask;
        else if (hit_dig)
            next_dat[NUM_CHAN-1:0] = pin_s2;
    end

    // one-cycle acknowledge with registered read data
    // ack drops one cycle after it rose because req excludes ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= req;
            if (rd)
                dat_o <= next_dat;
        end
    end

    // helper: conversion clocks counted from start, checked at completion
    logic [5:0] ticks_seen;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || go)
            ticks_seen <= 6'h00;
        else if (tick)
            ticks_seen <= ticks_seen + 6'h01;
    end

    // assertions
    a_start_midpoint: assert property (@(posedge clk_i) disable iff (rst_i)
        go |=> sar == sas_pkg::SAR_MIDPOINT && state == sas_pkg::ST_SETUP)
        else $error("conversion did not start at midpoint");
    a_start_clears_eoc: assert property (@(posedge clk_i) disable iff (rst_i)
        go |=> !ctl.eoc && ctl.start)
        else $error("start did not clear end flag");
    a_done_sets_eoc: assert property (@(posedge clk_i) disable iff (rst_i)
        last_bit |=> ctl.eoc && !ctl.start && state == sas_pkg::ST_IDLE)
        else $error("completion did not set end flag");
    a_result_split: assert property (@(posedge clk_i) disable iff (rst_i)
        last_bit |=> {res_high, res_low} == $past(kept))
        else $error("result registers wrong");
    a_setup_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state == sas_pkg::ST_TRIAL) |-> $past(step) == 4'(sas_pkg::SETUP_CLOCKS - 1))
        else $error("setup period wrong length");
    a_bit_update: assert property (@(posedge clk_i) disable iff (rst_i)
        decide && !last_bit |=> bitmask == ($past(bitmask) >> 1))
        else $error("approximation did not advance");
    a_tick_rate10: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && busy && ctl.speed == 2'b10 |=> !tick [*3] ##1 (tick || !busy))
        else $error("speed 10 tick spacing wrong");
    a_fast_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        busy && $past(busy) && ctl.speed == 2'b11 |-> tick)
        else $error("speed 11 should tick every cycle");
    a_one_channel: assert property (@(posedge clk_i) disable iff (rst_i)
        $onehot0(mux_sel_o))
        else $error("more than one channel selected");
    a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held too long");

    // assertions: timing, protection and results
    a_conv_length: assert property (@(posedge clk_i) disable iff (rst_i)
        last_bit |-> ticks_seen == 6'(sas_pkg::RESULT_BITS * sas_pkg::CLK_PER_BIT + sas_pkg::SETUP_CLOCKS - 1))
        else $error("conversion clock count wrong");
    a_rate01_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && !last_bit && ctl.speed == 2'b01 |=> !tick [*7] ##1 tick)
        else $error("speed 01 tick spacing wrong");
    a_setup_midpoint: assert property (@(posedge clk_i) disable iff (rst_i)
        state == sas_pkg::ST_SETUP |-> sar == sas_pkg::SAR_MIDPOINT)
        else $error("trial code moved during set-up");
    a_frozen_fields: assert property (@(posedge clk_i) disable iff (rst_i)
        busy |=> ctl.chan == $past(ctl.chan) && ctl.speed == $past(ctl.speed))
        else $error("channel or speed moved during conversion");
    a_idle_no_mux: assert property (@(posedge clk_i) disable iff (rst_i)
        !busy |-> mux_sel_o == '0)
        else $error("channel selected while idle");
    a_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
        busy |-> ctl.start)
        else $error("start bit low during conversion");
    a_eoc_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        ctl.eoc && !go |=> ctl.eoc)
        else $error("end flag lost without a start");
    a_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !last_bit |=> $stable({res_high, res_low}))
        else $error("result changed outside completion");
    a_done_status: assert property (@(posedge clk_i) disable iff (rst_i)
        last_bit |=> irq_stat[sas_pkg::IRQ_DONE_BIT])
        else $error("completion did not set done status");
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o)
        else $error("request not answered next cycle");

    c_conversion: cover property (@(posedge clk_i) disable iff (rst_i) last_bit);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    c_slow: cover property (@(posedge clk_i) disable iff (rst_i) go && dat_i[2:1] == 2'b00);
    c_fast: cover property (@(posedge clk_i) disable iff (rst_i) go && dat_i[2:1] == 2'b11);
    c_busy_write: cover property (@(posedge clk_i) disable iff (rst_i) start_req && busy);
endmodule

// *** sas_afe_model.sv ***
// behavioural analog front end: input levels, channel mux and comparator
module sas_afe_model (
    // clock
    input  wire logic        clk_i,
    // converter side
    input  wire logic [9:0]  dac_i,
    input  wire logic [8:0]  mux_sel_i,
    // analog levels, ten bits per channel
    input  wire logic [89:0] level_i,
    // comparator decision
    output logic             cmp_o
);
    logic       idle_tgl = 1'b0;
    logic [9:0] sel_level;
    int         hits;
    // with no single input selected the comparator wanders every cycle
    always_ff @(posedge clk_i)
    begin
        idle_tgl <= ~idle_tgl;
    end
    // high while the selected level is at or above the trial code
    always_comb
    begin
        hits = 0;
        sel_level = 10'h000;
        for (int k = 0; k < 9; k++)
        begin
            if (mux_sel_i[k] === 1'b1)
            begin
                hits++;
                sel_level = level_i[k*10 +: 10];
            end
        end
        cmp_o = (hits == 1) ? (sel_level >= dac_i) : idle_tgl;
    end
endmodule

// *** sas_sequencer_tb.sv ***
// self-checking testbench for the converter sequencer
module sas_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk_i, rst_i, cyc_i, stb_i, we_i, cmp_i, sample_o, ack_o, irq_o;
    logic [7:0]        adr_i;
    logic [3:0]        sel_i;
    logic [31:0]       dat_i, dat_o, q;
    logic [9:0]        dac_o;
    logic [8:0]        mux_sel_o, pin_i;
    logic [89:0]       lvl;
    int                fail_count, n_compared, cyc_n, t0, t_end, ch, v, d;
    int                exp_q[$];
    int                divs[4] = '{16, 8, 4, 1};
    sas_pkg::sas_ctl_t c;

    sas_sequencer sas_sequencer_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_i(cmp_i),
        .dac_o(dac_o), .mux_sel_o(mux_sel_o), .sample_o(sample_o), .pin_i(pin_i), .irq_o(irq_o));
    sas_afe_model sas_afe_model_i (.clk_i(clk_i), .dac_i(dac_o), .mux_sel_i(mux_sel_o), .level_i(lvl),
        .cmp_o(cmp_i));

    // clock and cycle count
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc_n <= cyc_n + 1;
    always @(negedge sample_o) t_end = cyc_n;

    // comparison with reporting
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one classic wishbone cycle, waits for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= dw;
        sel_i <= 4'h1;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        dr = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // verdict and end of run
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog sized for four conversions plus register traffic
    initial
    begin
        #(10000 * 5);
        fail_count++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        {rst_i, cyc_i, stb_i, we_i} = 4'b1000;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0000_0000;
        pin_i = 9'h000;
        lvl = '0;
        cyc_n = 0;
        void'($urandom(32'h8e1f72e9));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, sas_pkg::OFF_CONTROL, 32'h0, q);
        chk("ctl_reset", q, {24'h0, sas_pkg::CONTROL_RESET});
        wb(1'b0, sas_pkg::OFF_IRQ_MASK, 32'h0, q);
        chk("mask_reset", q, {30'h0, sas_pkg::MASK_RESET});
        wb(1'b0, 8'hd0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        pin_i <= 9'($urandom);
        repeat (4) @(posedge clk_i);
        wb(1'b0, sas_pkg::OFF_DIG_IN, 32'h0, q);
        chk("pins", q, {23'h0, pin_i});
        $display("test registers done");
        for (int sp = 0; sp < 4; sp++)
        begin
            d = divs[sp];
            wb(1'b1, sas_pkg::OFF_IRQ_MASK, {31'h0, sp != 3}, q);
            wb(1'b0, sas_pkg::OFF_IRQ_STAT, 32'h0, q);
            ch = $urandom % 9;
            v = $urandom % 1024;
            lvl[ch*10 +: 10] = v[9:0];
            exp_q.push_back(v);
            c = '{chan: ch[3:0], eoc: 1'b0, speed: sp[1:0], start: 1'b1};
            wb(1'b1, sas_pkg::OFF_CONTROL, {24'h0, c}, q);
            t0 = cyc_n;
            chk("dac_start", {22'h0, dac_o}, {22'h0, sas_pkg::SAR_MIDPOINT});
            chk("mux_sel", {23'h0, mux_sel_o}, 32'h1 << ch);
            // a write while busy must leave the conversion untouched
            wb(1'b1, sas_pkg::OFF_CONTROL, {24'h0, c.chan ^ 4'h1, 4'h1}, q);
            wb(1'b0, sas_pkg::OFF_CONTROL, 32'h0, q);
            chk("ctl_busy", q, {24'h0, c});
            chk("irq_busy", irq_o, 32'h0);
            if (sp == 0) repeat (3) @(posedge clk_i);
            do wb(1'b0, sas_pkg::OFF_CONTROL, 32'h0, q); while (q[3] !== 1'b1);
            chk("conv_time", (t_end - t0 >= 50 * d - 2) && (t_end - t0 <= 50 * d + 3), 32'h1);
            c.eoc = 1'b1;
            c.start = 1'b0;
            chk("ctl_done", q, {24'h0, c});
            chk("irq_level", irq_o, {31'h0, sp != 3});
            wb(1'b0, sas_pkg::OFF_IRQ_STAT, 32'h0, q);
            chk("irq_status", q, 32'h3);
            @(posedge clk_i);
            chk("irq_clear", irq_o, 32'h0);
            wb(1'b1, sas_pkg::OFF_RES_HIGH, 32'hff, q);
            v = exp_q.pop_front();
            wb(1'b0, sas_pkg::OFF_RES_HIGH, 32'h0, q);
            chk("res_high", q, v >> 2);
            wb(1'b0, sas_pkg::OFF_RES_LOW, 32'h0, q);
            chk("res_low", q, v & 3);
            $display("test conversion speed %0d done", sp);
        end
        // reset in mid-conversion returns everything to idle
        wb(1'b1, sas_pkg::OFF_CONTROL, 32'h0000_0001, q);
        repeat (5) @(posedge clk_i);
        chk("rst_busy", sample_o, 32'h1);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("rst_sample", sample_o, 32'h0);
        chk("rst_dac", {22'h0, dac_o}, 32'h0);
        chk("rst_mux", {23'h0, mux_sel_o}, 32'h0);
        wb(1'b0, sas_pkg::OFF_CONTROL, 32'h0, q);
        chk("rst_ctl", q, {24'h0, sas_pkg::CONTROL_RESET});
        wb(1'b0, sas_pkg::OFF_RES_HIGH, 32'h0, q);
        chk("rst_res", q, 32'h0);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
